// File: src/dtc_pkg.sv
// shared constants and types for the terminal command logic
package dtc_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CFG_OFS    = 8'h00;
  localparam logic [7:0] ASSIGN_OFS = 8'h04;
  localparam logic [7:0] MAXF_OFS   = 8'h08;
  localparam logic [7:0] RATE_OFS   = 8'h0c;
  localparam logic [7:0] PRATE_OFS  = 8'h10;
  localparam logic [7:0] FREQ_OFS   = 8'h14;
  localparam logic [7:0] PIDC_OFS   = 8'h18;
  localparam logic [7:0] STAT_OFS   = 8'h1c;
  // ==========================================================
  // field positions
  localparam int CFG_SRC1_LSB = 0;
  localparam int CFG_SRC2_LSB = 4;
  localparam int CFG_PMOD_LSB = 8;
  localparam int CFG_PREM_LSB = 10;
  localparam int CFG_PROT_LSB = 12;
  localparam int CFG_RET_BIT  = 14;
  localparam int CFG_INV_BIT  = 15;
  localparam int RATE_DEC_LSB = 16;
  // ==========================================================
  // reset values and coded settings
  localparam logic [31:0] CFG_RST    = 32'h0000_0000;
  localparam logic [1:0]  ASSIGN_RST = 2'h0;
  localparam logic [15:0] MAXF_RST   = 16'h1770;
  localparam logic [15:0] RATE_RST   = 16'h0001;
  localparam logic [6:0]  PRATE_RST  = 7'h0a;
  localparam logic [3:0]  SRC_STEP   = 4'h7;
  localparam logic [1:0]  PREM_STEP  = 2'h3;
  localparam logic [1:0]  PMOD_OFF   = 2'h0;
  localparam logic [1:0]  PMOD_INV   = 2'h2;
  localparam logic [1:0]  PMOD_DANCE = 2'h3;
  localparam logic [13:0] PID_FULL   = 14'h2710;
  localparam logic [6:0]  PRATE_MIN  = 7'h0a;
  localparam logic [6:0]  PRATE_MAX  = 7'h64;
  // ==========================================================
  // timing
  localparam int CLK_MHZ      = 100;
  localparam int TICK_MS      = 10;
  localparam int TICK_CYCLES  = TICK_MS * 1000 * CLK_MHZ;
  localparam int PID_TICKS    = 10;
  // ==========================================================
  // types
  typedef struct packed {
    logic dcBrake;
    logic torqueSel;
    logic up;
    logic down;
    logic keypadWe;
    logic pidCancel;
    logic inversion;
    logic freqSel;
    logic multistep0;
    logic commLink;
  } dtc_term_t;

  typedef struct packed {
    logic       writeReq;
    logic       targetIsProtect;
    logic       arrowKey;
  } dtc_kp_t;

  typedef enum logic [1:0] {
    ENT_FREQSEL,
    ENT_PIDCANCEL,
    ENT_OTHER
  } dtc_entry_t;
endpackage : dtc_pkg

// File: src/dtc_core.sv
// terminal command interpreter: braking, torque sets, stepping, protection
// Operation
// - dc brake terminal issues braking command
// - torque select picks limiter set 1/2
// - unassigned torque select means set 1
// - up raises, down lowers, both hold
// - clamp 0..max, step only while running
// - retention 0 restarts from zero
// - retention 1 restores stored frequency
// - step during restore stores present frequency
// - source switch entry takes previous reference
// - pid cancel entry takes pid output
// - multistep/link entry depends on retention
// - stepping only when source set to 7
// - pid command 0..100%, bounded rate
// - dancer mode always retains pid command
// - pid stepping only when remote source 3
// - keypad write gated by enable and protection
// - unassigned keypad enable counts as on
// - arrow keys never blocked by enable
// - pid cancel selects manual reference
// - inversion flips pid/manual control sense
// - analog cmd1 direction is xor
//
// Implementation choices: the address map and the AHB-Lite register port.
`timescale 1ns/1ps
module dtc_core #(
  parameter int TICK_CYCLES = dtc_pkg::TICK_CYCLES,
  parameter int FREQ_W      = 16
) (
  input  wire logic              core_clk,
  input  wire logic              srst,
  input  wire logic              ce,
  // ahb-lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic                   hresp,
  output logic [31:0]            hrdata,
  // terminals and drive side
  input  wire dtc_pkg::dtc_term_t terminals,
  input  wire logic              runCmd,
  input  wire logic [FREQ_W-1:0] prevSourceRef,
  input  wire logic [FREQ_W-1:0] pidOutputRef,
  input  wire dtc_pkg::dtc_kp_t  keypadReq,
  output logic                   dcBrakeRequest,
  output logic                   torqueLimitSetSelect,
  output logic                   keypadWriteAllow,
  output logic                   pidEnable,
  output logic                   pidInvert,
  output logic                   analogInvert,
  output logic                   freqStepActive,
  output logic [FREQ_W-1:0]      stepFreq,
  output logic [13:0]            pidCommand
);
  // ==========================================================
  // elaboration checks
  if (TICK_CYCLES < 1 || FREQ_W < 8 || FREQ_W > 16)
  begin : g_chk
    $error("dtc_core: unsupported parameter");
  end

  // ==========================================================
  // terminal synchroniser
  dtc_pkg::dtc_term_t termMeta;
  dtc_pkg::dtc_term_t term;
  dtc_pkg::dtc_term_t termLast;

  // two-flop sync; term moves only on two agreeing samples
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      termMeta <= '0;
      term     <= '0;
      termLast <= '0;
    end
    else if (ce)
    begin
      termMeta <= terminals;
      term     <= dtc_pkg::dtc_term_t'((termMeta & terminals) | (term & (termMeta | terminals)));
      termLast <= term;
    end
  end

  // ==========================================================
  // register file
  logic [31:0]       cfg;
  logic [1:0]        assign_;
  logic [FREQ_W-1:0] maxFreq;
  logic [FREQ_W-1:0] accStep;
  logic [FREQ_W-1:0] decStep;
  logic [6:0]        pidRate;
  logic              wrPend;
  logic [7:0]        wrAddr;

  // source code compare, used for both frequency sources
  function automatic logic isStepSrc(input logic [3:0] v);
    return v == dtc_pkg::SRC_STEP;
  endfunction : isStepSrc

  wire logic [3:0] src1  = cfg[dtc_pkg::CFG_SRC1_LSB +: 4];
  wire logic [3:0] src2  = cfg[dtc_pkg::CFG_SRC2_LSB +: 4];
  wire logic [1:0] pMode = cfg[dtc_pkg::CFG_PMOD_LSB +: 2];
  wire logic [1:0] pRem  = cfg[dtc_pkg::CFG_PREM_LSB +: 2];
  wire logic [1:0] prot  = cfg[dtc_pkg::CFG_PROT_LSB +: 2];
  wire logic       ret   = cfg[dtc_pkg::CFG_RET_BIT];
  wire logic       invSel = cfg[dtc_pkg::CFG_INV_BIT];

  wire logic addrPhase = hsel && htrans[1] && hready;

  // no wait states, never an error
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // capture write address phase
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
    end
    else if (ce && hready)
    begin
      wrPend <= addrPhase && hwrite;
      wrAddr <= haddr[7:0];
    end
  end

  // write data phase
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cfg     <= dtc_pkg::CFG_RST;
      assign_ <= dtc_pkg::ASSIGN_RST;
      maxFreq <= dtc_pkg::MAXF_RST[FREQ_W-1:0];
      accStep <= dtc_pkg::RATE_RST[FREQ_W-1:0];
      decStep <= dtc_pkg::RATE_RST[FREQ_W-1:0];
      pidRate <= dtc_pkg::PRATE_RST;
    end
    else if (ce && wrPend)
    begin
      unique case (wrAddr)
        dtc_pkg::CFG_OFS:    cfg     <= {16'h0000, hwdata[15:0]};
        dtc_pkg::ASSIGN_OFS: assign_ <= hwdata[1:0];
        dtc_pkg::MAXF_OFS:   maxFreq <= hwdata[FREQ_W-1:0];
        dtc_pkg::RATE_OFS:
        begin
          accStep <= hwdata[FREQ_W-1:0];
          decStep <= hwdata[dtc_pkg::RATE_DEC_LSB +: FREQ_W];
        end
        dtc_pkg::PRATE_OFS:
          pidRate <= (hwdata[6:0] < dtc_pkg::PRATE_MIN) ? dtc_pkg::PRATE_MIN :
                     (hwdata[6:0] > dtc_pkg::PRATE_MAX) ? dtc_pkg::PRATE_MAX :
                     hwdata[6:0];
        default: ;
      endcase
    end
  end

  // status word for reads
  logic [31:0] statWord;
  assign statWord = {24'h000000, freqStepActive, analogInvert, pidInvert,
                     pidEnable, keypadWriteAllow, torqueLimitSetSelect,
                     dcBrakeRequest, runCmd};

  // read data registered at the address phase
  always_ff @(posedge core_clk)
  begin
    if (srst)
      hrdata <= 32'h0000_0000;
    else if (ce && hready)
    begin
      if (addrPhase && !hwrite)
      begin
        unique case (haddr[7:0])
          dtc_pkg::CFG_OFS:    hrdata <= cfg;
          dtc_pkg::ASSIGN_OFS: hrdata <= {30'h00000000, assign_};
          dtc_pkg::MAXF_OFS:   hrdata <= 32'(maxFreq);
          dtc_pkg::RATE_OFS:   hrdata <= {16'(decStep), 16'(accStep)};
          dtc_pkg::PRATE_OFS:  hrdata <= {25'h0000000, pidRate};
          dtc_pkg::FREQ_OFS:   hrdata <= 32'(stepFreq);
          dtc_pkg::PIDC_OFS:   hrdata <= {18'h00000, pidCommand};
          dtc_pkg::STAT_OFS:   hrdata <= statWord;
          default:             hrdata <= 32'h0000_0000;
        endcase
      end
      else
        hrdata <= 32'h0000_0000;
    end
  end

  // ==========================================================
  // selections
  // braking follows terminal
  assign dcBrakeRequest = term.dcBrake;
  // set 2 only when assigned and on
  assign torqueLimitSetSelect = assign_[0] && term.torqueSel;

  logic kpEnable;
  assign kpEnable = !assign_[1] || term.keypadWe;

  always_comb
  begin
    keypadWriteAllow = 1'b0;
    if (keypadReq.writeReq)
    begin
      if (keypadReq.arrowKey)
        keypadWriteAllow = 1'b1;
      else if (kpEnable)
        keypadWriteAllow = !prot[0] || keypadReq.targetIsProtect;
    end
  end

  assign pidEnable = (pMode != dtc_pkg::PMOD_OFF) && !term.pidCancel;
  // pid sense follows mode xor inversion
  assign pidInvert = (pMode == dtc_pkg::PMOD_INV) ^ term.inversion;
  assign analogInvert = invSel ^ term.inversion;

  // ==========================================================
  // step rate tick
  logic [31:0] tickCnt;
  logic [3:0]  pidDiv;
  logic        tick;
  logic        pidTick;
  assign tick    = tickCnt == 32'(TICK_CYCLES - 1);
  assign pidTick = tick && pidDiv == 4'(dtc_pkg::PID_TICKS - 1);

  // free tick; pid rate is per ten ticks
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      tickCnt <= 32'h0000_0000;
      pidDiv  <= 4'h0;
    end
    else if (ce)
    begin
      tickCnt <= tick ? 32'h0000_0000 : tickCnt + 32'h0000_0001;
      if (tick)
        pidDiv <= pidTick ? 4'h0 : pidDiv + 4'h1;
    end
  end

  // ==========================================================
  // frequency stepping
  logic stepSel;
  logic stepSelLast;
  logic runLast;
  logic restoring;
  logic [FREQ_W-1:0] heldFreq;
  logic upOnly;
  logic downOnly;
  logic [FREQ_W:0]   upSum;
  logic [FREQ_W-1:0] downVal;
  logic [FREQ_W-1:0] incFreq;

  // active source must be set to 7
  assign stepSel = (term.freqSel ? isStepSrc(src2) : isStepSrc(src1)) &&
                   !term.multistep0 && term.commLink && !pidEnable;
  assign freqStepActive = stepSel;
  assign upOnly   = term.up && !term.down;
  assign downOnly = term.down && !term.up;

  assign upSum   = {1'b0, stepFreq} + {1'b0, accStep};
  assign incFreq = (upSum > {1'b0, maxFreq}) ? maxFreq : upSum[FREQ_W-1:0];
  assign downVal = (stepFreq > decStep) ? stepFreq - decStep : '0;

  // entry cause from the input that just changed
  dtc_pkg::dtc_entry_t entry;
  always_comb
  begin
    if (term.freqSel != termLast.freqSel)
      entry = dtc_pkg::ENT_FREQSEL;
    else if (term.pidCancel != termLast.pidCancel)
      entry = dtc_pkg::ENT_PIDCANCEL;
    else
      entry = dtc_pkg::ENT_OTHER;
  end

  // mode and run edge memory
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stepSelLast <= 1'b0;
      runLast     <= 1'b0;
    end
    else if (ce)
    begin
      stepSelLast <= stepSel;
      runLast     <= runCmd;
    end
  end

  // stepped frequency, held copy, restore ramp
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      stepFreq  <= '0;
      heldFreq  <= '0;
      restoring <= 1'b0;
    end
    else if (ce)
    begin
      if (stepSel && !stepSelLast)
      begin
        restoring <= 1'b0;
        unique case (entry)
          dtc_pkg::ENT_FREQSEL:   stepFreq <= prevSourceRef;
          dtc_pkg::ENT_PIDCANCEL: stepFreq <= pidOutputRef;
          dtc_pkg::ENT_OTHER:     stepFreq <= ret ? heldFreq : prevSourceRef;
        endcase
      end
      else if (stepSel && runCmd && !runLast)
      begin
        // restart from zero; ramp to held only with retention on
        stepFreq  <= '0;
        restoring <= ret && heldFreq != '0;
        if (!ret)
          heldFreq <= '0;
      end
      else if (stepSel && runCmd && tick)
      begin
        if (restoring && (upOnly || downOnly))
        begin
          restoring <= 1'b0;
          heldFreq  <= stepFreq;
        end
        else if (restoring)
        begin
          if (incFreq >= heldFreq)
          begin
            stepFreq  <= heldFreq;
            restoring <= 1'b0;
          end
          else
            stepFreq <= incFreq;
        end
        else if (upOnly)
        begin
          stepFreq <= incFreq;
          heldFreq <= incFreq;
        end
        else if (downOnly)
        begin
          stepFreq <= downVal;
          heldFreq <= downVal;
        end
      end
    end
  end

  // ==========================================================
  // pid speed command stepping
  logic pidStepOk;
  logic pidRetain;
  logic [14:0] pidUp;
  assign pidStepOk = pidEnable && pRem == dtc_pkg::PREM_STEP;
  assign pidRetain = ret || pMode == dtc_pkg::PMOD_DANCE;
  assign pidUp = {1'b0, pidCommand} + 15'(pidRate);

  always_ff @(posedge core_clk)
  begin
    if (srst)
      pidCommand <= 14'h0000;
    else if (ce && pidStepOk)
    begin
      if (runCmd && !runLast && !pidRetain)
        pidCommand <= 14'h0000;
      else if (runCmd && pidTick && upOnly)
        pidCommand <= (pidUp > {1'b0, dtc_pkg::PID_FULL}) ?
                      dtc_pkg::PID_FULL : pidUp[13:0];
      else if (runCmd && pidTick && downOnly)
        pidCommand <= (pidCommand > 14'(pidRate)) ?
                      pidCommand - 14'(pidRate) : 14'h0000;
    end
  end
endmodule : dtc_core

// File: verification/dtc_core_properties.sv
// concurrent checks on the terminal command logic ports
`timescale 1ns/1ps
module dtc_core_properties #(
  parameter int FREQ_W = 16
) (
  input wire logic               core_clk,
  input wire logic               srst,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire dtc_pkg::dtc_term_t terminals,
  input wire logic               runCmd,
  input wire dtc_pkg::dtc_kp_t   keypadReq,
  input wire logic               dcBrakeRequest,
  input wire logic               torqueLimitSetSelect,
  input wire logic               keypadWriteAllow,
  input wire logic               pidEnable,
  input wire logic               freqStepActive,
  input wire logic [FREQ_W-1:0]  stepFreq,
  input wire logic [13:0]        pidCommand
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ==========================================================
  // sequences: a level held for two samples clears the synchroniser
  sequence s_brake_on;
    terminals.dcBrake ##1 terminals.dcBrake;
  endsequence
  sequence s_brake_off;
    !terminals.dcBrake ##1 !terminals.dcBrake;
  endsequence
  sequence s_brake_pulse;
    !terminals.dcBrake ##1 terminals.dcBrake ##1 !terminals.dcBrake;
  endsequence
  sequence s_cancel_on;
    terminals.pidCancel ##1 terminals.pidCancel;
  endsequence
  // ==========================================================
  // properties
  property p_brake_on;
    s_brake_on |-> ##1 dcBrakeRequest;
  endproperty
  property p_brake_off;
    s_brake_off |-> ##1 !dcBrakeRequest;
  endproperty
  property p_torque;
    $rose(torqueLimitSetSelect) |-> $past(terminals.torqueSel, 1) || $past(terminals.torqueSel, 2);
  endproperty
  // a one-sample pulse on the terminal never reaches the request
  property p_glitch;
    !dcBrakeRequest ##0 s_brake_pulse |-> ##1 !dcBrakeRequest ##1 !dcBrakeRequest;
  endproperty
  property p_kp_idle;
    !keypadReq.writeReq |-> !keypadWriteAllow;
  endproperty
  property p_kp_arrow;
    keypadReq.writeReq && keypadReq.arrowKey |-> keypadWriteAllow;
  endproperty
  property p_cancel;
    s_cancel_on |-> ##1 !pidEnable;
  endproperty
  property p_step_pid;
    freqStepActive |-> !pidEnable;
  endproperty
  // both keys held with nothing else moving: no step at all
  property p_hold;
    (runCmd && freqStepActive && terminals.up && terminals.down && $stable(terminals))[*4]
      |-> $stable(stepFreq);
  endproperty
  property p_pid_max;
    pidCommand <= dtc_pkg::PID_FULL;
  endproperty
  property p_bus;
    hreadyout && !hresp;
  endproperty
  a_brake_on: assert property (p_brake_on) else $error("brake request missing");
  a_brake_off: assert property (p_brake_off) else $error("brake request stuck");
  a_torque: assert property (p_torque) else $error("set 2 without terminal");
  a_kp_idle: assert property (p_kp_idle) else $error("allow without request");
  a_kp_arrow: assert property (p_kp_arrow) else $error("arrow key blocked");
  a_cancel: assert property (p_cancel) else $error("pid still enabled");
  a_step_pid: assert property (p_step_pid) else $error("stepping under pid");
  a_hold: assert property (p_hold) else $error("frequency moved on hold");
  a_pid_max: assert property (p_pid_max) else $error("pid command above full");
  a_bus: assert property (p_bus) else $error("bus wait or error");
  a_glitch: assert property (p_glitch) else $error("glitch reached brake request");
endmodule : dtc_core_properties

// File: verification/dtc_term_model.sv
// external switch bank: presents terminal levels just after a clock edge
`timescale 1ns/1ps
module dtc_term_model (
  input  wire logic               core_clk,
  input  wire dtc_pkg::dtc_term_t want,
  output dtc_pkg::dtc_term_t      terminals
);
  // ==========================================================
  // contacts change only after an edge, so no sample sees a half step
  always_ff @(posedge core_clk)
  begin
    terminals <= want;
  end
endmodule : dtc_term_model

// File: verification/test_drive_terminal_command_logic.sv
// self-checking bench for the terminal command logic
`timescale 1ns/1ps
module test_drive_terminal_command_logic;
  localparam int TK = 8;
  logic               core_clk = 1'b0;
  logic               srst = 1'b1;
  logic               hsel = 1'b0;
  logic [31:0]        haddr = 32'h0;
  logic [1:0]         htrans = 2'h0;
  logic               hwrite = 1'b0;
  logic [31:0]        hwdata = 32'h0;
  logic               hreadyout;
  logic               hresp;
  logic [31:0]        hrdata;
  logic [31:0]        rd;
  dtc_pkg::dtc_term_t term = '0;
  dtc_pkg::dtc_term_t terminals;
  logic               runCmd = 1'b0;
  logic [15:0]        prevRef = 16'h0;
  logic [15:0]        pidRef = 16'h0;
  logic [15:0]        stepFreq;
  dtc_pkg::dtc_kp_t   kp = '0;
  logic               dc_brake_request;
  logic               tlSel;
  logic               kpAllow;
  logic               pidEn;
  logic               pidInv;
  logic               anaInv;
  logic               stepAct;
  logic [13:0]        pidCmd;
  int                 n_mismatch = 0;
  int                 check_count = 0;
  // ==========================================================
  // clock, switch model and design
  always #5 core_clk = ~core_clk;
  dtc_term_model u_term (.core_clk(core_clk), .want(term), .terminals(terminals));
  dtc_core #(.TICK_CYCLES(TK)) uut (
    .core_clk(core_clk), .srst(srst), .ce(1'b1), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .terminals(terminals),
    .runCmd(runCmd), .prevSourceRef(prevRef), .pidOutputRef(pidRef), .keypadReq(kp),
    .dcBrakeRequest(dc_brake_request), .torqueLimitSetSelect(tlSel), .keypadWriteAllow(kpAllow),
    .pidEnable(pidEn), .pidInvert(pidInv), .analogInvert(anaInv),
    .freqStepActive(stepAct), .stepFreq(stepFreq), .pidCommand(pidCmd));
  // ==========================================================
  // shared tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // wait n edges, then look where outputs have settled
  task automatic wt(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask : wt
  // one single ahb transfer; holds each phase until hready is seen high
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    hsel <= 1'b1;
    // only the watchdog ends a wait
    for (int p = 0; p < 2; p++)
    begin
      do
        @(posedge core_clk);
      while (hreadyout !== 1'b1);
      if (p == 0)
      begin
        htrans <= 2'h0;
        hwdata <= d;
      end
    end
    // read data taken at the edge that ends the data phase
    rd = hrdata;
  endtask : bus
  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(what, exp, rd);
  endtask : rdchk
  // ==========================================================
  // scenarios
  task automatic t_regs();
    rdchk("cfg", dtc_pkg::CFG_OFS, dtc_pkg::CFG_RST);
    rdchk("maxf", dtc_pkg::MAXF_OFS, {16'h0, dtc_pkg::MAXF_RST});
    rdchk("rate", dtc_pkg::RATE_OFS, 32'h0001_0001);
    rdchk("prate", dtc_pkg::PRATE_OFS, {25'h0, dtc_pkg::PRATE_RST});
    bus(1'b1, 8'h40, 32'hffff_ffff);
    rdchk("unmapped", 8'h40, 32'h0);
    bus(1'b1, dtc_pkg::FREQ_OFS, 32'h0000_ffff);
    rdchk("freq ro", dtc_pkg::FREQ_OFS, 32'h0);
    $display("test regs done");
  endtask : t_regs
  task automatic t_brake();
    @(posedge core_clk);
    term.dcBrake <= 1'b1;
    term.torqueSel <= 1'b1;
    wt(4);
    chk("brake", 32'h1, 32'(dc_brake_request));
    chk("torque unassigned", 32'h0, 32'(tlSel));
    bus(1'b1, dtc_pkg::ASSIGN_OFS, 32'h1);
    wt(2);
    chk("torque set2", 32'h1, 32'(tlSel));
    @(posedge core_clk);
    term.dcBrake <= 1'b0;
    term.torqueSel <= 1'b0;
    wt(4);
    chk("torque set1", 32'h0, 32'(tlSel));
    chk("brake off", 32'h0, 32'(dc_brake_request));
    @(posedge core_clk);
    term.dcBrake <= 1'b1;
    @(posedge core_clk);
    term.dcBrake <= 1'b0;
    wt(2);
    chk("brake glitch", 32'h0, 32'(dc_brake_request));
    $display("test brake done");
  endtask : t_brake
  task automatic t_keypad();
    @(posedge core_clk);
    kp.writeReq <= 1'b1;
    wt(1);
    chk("kp unassigned", 32'h1, 32'(kpAllow));
    bus(1'b1, dtc_pkg::ASSIGN_OFS, 32'h3);
    wt(2);
    chk("kp off", 32'h0, 32'(kpAllow));
    @(posedge core_clk);
    kp.arrowKey <= 1'b1;
    wt(1);
    chk("kp arrow", 32'h1, 32'(kpAllow));
    @(posedge core_clk);
    kp.arrowKey <= 1'b0;
    term.keypadWe <= 1'b1;
    for (int p = 0; p < 4; p++)
    begin
      bus(1'b1, dtc_pkg::CFG_OFS, 32'(p) << 12);
      kp.targetIsProtect <= 1'b0;
      wt(4);
      chk("kp protect", 32'(p % 2 == 0), 32'(kpAllow));
      @(posedge core_clk);
      kp.targetIsProtect <= 1'b1;
      wt(1);
      chk("kp own", 32'h1, 32'(kpAllow));
    end
    $display("test keypad done");
  endtask : t_keypad
  task automatic t_step();
    bus(1'b1, dtc_pkg::MAXF_OFS, 32'h200);
    bus(1'b1, dtc_pkg::RATE_OFS, 32'h0040_0040);
    bus(1'b1, dtc_pkg::CFG_OFS, 32'h7);
    term.commLink <= 1'b1;
    term.up <= 1'b1;
    runCmd <= 1'b1;
    wt(12 * TK);
    chk("up clamp max", 32'h200, 32'(stepFreq));
    @(posedge core_clk);
    term.down <= 1'b1;
    wt(5 * TK);
    chk("both hold", 32'h200, 32'(stepFreq));
    @(posedge core_clk);
    term.up <= 1'b0;
    wt(12 * TK);
    chk("down clamp zero", 32'h0, 32'(stepFreq));
    @(posedge core_clk);
    term <= '{up: 1'b1, commLink: 1'b1, default: 1'b0};
    runCmd <= 1'b0;
    wt(5 * TK);
    chk("no run", 32'h0, 32'(stepFreq));
    bus(1'b1, dtc_pkg::CFG_OFS, 32'h0);
    runCmd <= 1'b1;
    wt(5 * TK);
    chk("source not 7", 32'h0, 32'(stepFreq));
    chk("not stepping", 32'h0, 32'(stepAct));
    $display("test step done");
  endtask : t_step
  task automatic t_entry();
    bus(1'b1, dtc_pkg::CFG_OFS, 32'h70);
    term.up <= 1'b0;
    term.freqSel <= 1'b1;
    prevRef <= 16'h123;
    wt(8);
    chk("entry source", 32'h123, 32'(stepFreq));
    @(posedge core_clk);
    runCmd <= 1'b0;
    wt(2);
    @(posedge core_clk);
    runCmd <= 1'b1;
    wt(4);
    chk("restart clear", 32'h0, 32'(stepFreq));
    bus(1'b1, dtc_pkg::CFG_OFS, 32'h4070);
    term.up <= 1'b1;
    wt(12 * TK);
    @(posedge core_clk);
    term.up <= 1'b0;
    runCmd <= 1'b0;
    wt(2);
    @(posedge core_clk);
    runCmd <= 1'b1;
    wt(12 * TK);
    chk("restart held", 32'h200, 32'(stepFreq));
    bus(1'b1, dtc_pkg::CFG_OFS, 32'h0107);
    term.freqSel <= 1'b0;
    pidRef <= 16'h156;
    wt(8);
    chk("pid on", 32'h1, 32'(pidEn));
    @(posedge core_clk);
    term.pidCancel <= 1'b1;
    wt(8);
    chk("pid cancelled", 32'h0, 32'(pidEn));
    chk("entry pid", 32'h156, 32'(stepFreq));
    $display("test entry done");
  endtask : t_entry
  task automatic t_invert();
    @(posedge core_clk);
    term.pidCancel <= 1'b0;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, dtc_pkg::CFG_OFS, (32'(i / 2 % 2) << 15) | (32'(1 + i / 4) << 8));
      term.inversion <= i[0];
      wt(4);
      chk("pid invert", 32'(i[0] ^ i[2]), 32'(pidInv));
      chk("analog invert", 32'(i[0] ^ i[1]), 32'(anaInv));
    end
    $display("test invert done");
  endtask : t_invert
  // pid command stepping: clamp, hold, retention by mode, remote source gate
  task automatic t_pid();
    bus(1'b1, dtc_pkg::PRATE_OFS, 32'hff);
    rdchk("prate clamp", dtc_pkg::PRATE_OFS, {25'h0, dtc_pkg::PRATE_MAX});
    bus(1'b1, dtc_pkg::CFG_OFS, 32'h0f00);
    term.up <= 1'b1;
    wt(110 * dtc_pkg::PID_TICKS * TK);
    chk("pid clamp full", {18'h0, dtc_pkg::PID_FULL}, 32'(pidCmd));
    @(posedge core_clk);
    term.down <= 1'b1;
    wt(2 * dtc_pkg::PID_TICKS * TK);
    chk("pid both hold", {18'h0, dtc_pkg::PID_FULL}, 32'(pidCmd));
    @(posedge core_clk);
    runCmd <= 1'b0;
    @(posedge core_clk);
    runCmd <= 1'b1;
    wt(4);
    chk("pid dancer keeps", {18'h0, dtc_pkg::PID_FULL}, 32'(pidCmd));
    bus(1'b1, dtc_pkg::CFG_OFS, 32'h0d00);
    @(posedge core_clk);
    runCmd <= 1'b0;
    @(posedge core_clk);
    runCmd <= 1'b1;
    wt(4);
    chk("pid process clears", 32'h0, 32'(pidCmd));
    bus(1'b1, dtc_pkg::CFG_OFS, 32'h0900);
    term.down <= 1'b0;
    wt(2 * dtc_pkg::PID_TICKS * TK);
    chk("pid remote not 3", 32'h0, 32'(pidCmd));
    $display("test pid done");
  endtask : t_pid
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : finish_test
  // ==========================================================
  // main sequence and watchdog
  initial
  begin
    repeat (20) @(posedge core_clk);
    srst <= 1'b0;
    t_regs();
    t_brake();
    t_keypad();
    t_step();
    t_entry();
    t_invert();
    t_pid();
    finish_test();
  end
  initial
  begin
    #300000;
    n_mismatch++;
    finish_test();
  end
endmodule : test_drive_terminal_command_logic
bind dtc_core dtc_core_properties #(.FREQ_W(FREQ_W)) u_props (
  .core_clk(core_clk), .srst(srst), .hreadyout(hreadyout), .hresp(hresp),
  .terminals(terminals), .runCmd(runCmd), .keypadReq(keypadReq),
  .dcBrakeRequest(dcBrakeRequest), .torqueLimitSetSelect(torqueLimitSetSelect),
  .keypadWriteAllow(keypadWriteAllow), .pidEnable(pidEnable),
  .freqStepActive(freqStepActive), .stepFreq(stepFreq), .pidCommand(pidCommand));
